// ==== logic/acs_pkg.sv ====
package acs_pkg;

    // Timing, all at a 10 ns clock.
    localparam int CLK_NS = 10;
    localparam int SUPPLY_US = 100;
    localparam int CHARGE_US = 10;
    localparam int REF_MS = 8;
    localparam int RT_MS = 100;
    localparam int CAL_S = 1;
    localparam int SETTLE_CYC = ((SUPPLY_US + CHARGE_US) * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int REF_CYC = (REF_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int RT_CYC = RT_MS * 1000000 / CLK_NS;
    localparam int CAL_CYC = CAL_S * 1000000000 / CLK_NS;

    // Engine internal register addresses and words.
    localparam logic [7:0] ENG_CONV = 8'h00;
    localparam logic [7:0] ENG_CTRL = 8'h01;
    localparam logic [7:0] ENG_GAIN = 8'h04;
    localparam logic [7:0] ENG_OFFS = 8'h05;
    localparam logic [15:0] ENABLE_WORD = 16'h8000;
    localparam logic [6:0] SAMP_25 = 7'h40;
    localparam logic [6:0] SAMP_75 = 7'h02;
    localparam logic CHAN_25 = 1'b0;
    localparam logic CHAN_75 = 1'b1;
    localparam logic [15:0] IDEAL_25 = 16'h0400;
    localparam logic [15:0] IDEAL_75 = 16'h0c00;
    localparam logic [14:0] GAIN_ONE = 15'h4000;

    // Software register offsets.
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CFG = 4'h1;
    localparam logic [3:0] REG_OFF_LIM = 4'h2;
    localparam logic [3:0] REG_GAIN_LIM = 4'h3;
    localparam logic [3:0] REG_NOISE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_FILT0 = 4'h6;
    localparam logic [3:0] REG_COEF0 = 4'hc;

    localparam logic [15:0] CFG_RST = 16'h0232;
    localparam logic [15:0] OFF_LIM_RST = 16'h0100;
    localparam logic [15:0] GAIN_LIM_RST = 16'h0100;
    localparam logic [15:0] NOISE_RST = 16'h0008;

    typedef struct packed {
        logic [11:0] rsv;
        logic drift_clr;
        logic update;
        logic run_en;
        logic start;
    } acs_ctrl_t;

    typedef struct packed {
        logic [4:0] rsv;
        logic [2:0] drift_thr;
        logic [3:0] fgain;
        logic rsv1;
        logic [2:0] nlog;
    } acs_cfg_t;

    typedef struct packed {
        logic [6:0] rsv;
        logic eng;
        logic wait_coef;
        logic run;
        logic fail;
        logic [1:0] drift;
        logic [1:0] done;
        logic clk_final;
    } acs_status_t;

    typedef struct packed {
        logic engine;
        logic top_q;
        logic reg_wr;
        logic [7:0] reg_addr;
        logic [15:0] data;
        logic chan;
        logic [6:0] samp;
        logic cal_apply;
        logic [1:0] tag;
    } acs_cmd_t;

    typedef struct packed {
        logic engine;
        logic [1:0] tag;
        logic [15:0] data;
    } acs_res_t;

    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_ENABLE = 12'h002,
        ST_SETTLE = 12'h004,
        ST_REFWAIT = 12'h008,
        ST_SAMPLE = 12'h010,
        ST_WAITRES = 12'h020,
        ST_COEFWAIT = 12'h040,
        ST_CHECK = 12'h080,
        ST_WR_OFF = 12'h100,
        ST_WR_GAIN = 12'h200,
        ST_RUN = 12'h400,
        ST_FAIL = 12'h800
    } acs_state_t;

endpackage : acs_pkg

// ==== logic/acs_coef_mem.sv ====
`timescale 1ns/10ps
// Coefficient store: one 32-bit word per engine, offset in the low half, gain in the high.
module acs_coef_mem (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Write port, one enable per half
    input wire logic [1:0] i_we,
    input wire logic i_waddr,
    input wire logic [15:0] i_wdata,
    // Registered read ports
    input wire logic i_raddr_a,
    output logic [31:0] o_rdata_a,
    input wire logic i_raddr_b,
    output logic [31:0] o_rdata_b
);
    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            // Each half owns its array, so no two processes write one variable.
            logic [15:0] half_ff [0:1];
            logic [15:0] rd_a_ff, rd_b_ff;
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    half_ff[0] <= 16'h0000;
                    half_ff[1] <= 16'h0000;
                    rd_a_ff <= 16'h0000;
                    rd_b_ff <= 16'h0000;
                end else begin
                    if (i_we[h]) begin
                        half_ff[i_waddr] <= i_wdata;
                    end
                    rd_a_ff <= half_ff[i_raddr_a];
                    rd_b_ff <= half_ff[i_raddr_b];
                end
            end
            assign o_rdata_a[h*16 +: 16] = rd_a_ff;
            assign o_rdata_b[h*16 +: 16] = rd_b_ff;
        end
    endgenerate
endmodule : acs_coef_mem

// ==== logic/acs_cal_seq.sv ====
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
module acs_cal_seq #(
    parameter int unsigned SETTLE_CYCLES = acs_pkg::SETTLE_CYC,
    parameter int unsigned REF_CYCLES = acs_pkg::REF_CYC,
    parameter int unsigned RT_CYCLES = acs_pkg::RT_CYC,
    parameter int unsigned CAL_CYCLES = acs_pkg::CAL_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [acs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Engine side
    output logic o_clk_final,
    output logic o_cmd_valid,
    output acs_pkg::acs_cmd_t o_cmd,
    input wire logic i_cmd_ready,
    input wire logic i_res_valid,
    input wire acs_pkg::acs_res_t i_res
);
    import acs_pkg::*;

    function automatic logic is_coef(input logic [3:0] a);
        is_coef = (a[3:2] == REG_COEF0[3:2]);
    endfunction : is_coef

    function automatic logic [16:0] mag(input logic signed [16:0] v);
        mag = v[16] ? 17'(-v) : v;
    endfunction : mag

    function automatic acs_cmd_t mk_cmd(input logic eng, input logic top, input logic wr,
                                         input logic [7:0] ra, input logic [15:0] d,
                                         input logic ch, input logic cal);
        acs_cmd_t c;
        c.engine = eng;
        c.top_q = top;
        c.reg_wr = wr;
        c.reg_addr = ra;
        c.data = d;
        c.chan = ch;
        c.samp = (ch == CHAN_25) ? SAMP_25 : SAMP_75;
        c.cal_apply = cal;
        c.tag = {1'b0, ch};
        mk_cmd = c;
    endfunction : mk_cmd

    // Register port state.
    acs_ctrl_t ctrl_ff, nxt_ctrl;
    acs_cfg_t cfg_ff, nxt_cfg;
    logic [15:0] off_lim_ff, nxt_off_lim, gain_lim_ff, nxt_gain_lim, noise_ff, nxt_noise;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [1:0] csel_ff, nxt_csel;
    logic start_p, upd_p, dclr_p;
    logic [31:0] coef_a, coef_b;
    acs_status_t status;

    // Sequencer state.
    acs_state_t state_ff, nxt_state;
    logic eng_ff, nxt_eng, clkf_ff, nxt_clkf, run_ff, nxt_run, vfy_ff, nxt_vfy;
    logic fail_ff, nxt_fail, bad_ff, nxt_bad, cval_ff, nxt_cval;
    logic upd_req_ff, nxt_upd_req;
    logic [1:0] done_ff, nxt_done, drift_ff, nxt_drift;
    logic [8:0] cnt_ff, nxt_cnt, tot;
    logic [23:0] sum25_ff, nxt_sum25, sum75_ff, nxt_sum75;
    logic [15:0] avg_ff [0:3];
    logic [15:0] nxt_avg [0:3];
    logic [15:0] base_ff [0:3];
    logic [15:0] nxt_base [0:3];
    logic [31:0] tmr_ff, nxt_tmr, ctmr_ff, nxt_ctmr, pwr_ff, nxt_pwr;
    acs_cmd_t cmd_ff, nxt_cmd;
    logic [1:0] idx;
    logic signed [16:0] diff, step;
    logic [15:0] ideal, filt;
    logic accepted, off_ok, gain_ok;

    acs_coef_mem u_mem (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we({2{i_wr & is_coef(i_addr)}} & {i_addr[0], ~i_addr[0]}),
        .i_waddr(i_addr[1]),
        .i_wdata(i_wdata),
        .i_raddr_a(i_addr[1]),
        .o_rdata_a(coef_a),
        .i_raddr_b(eng_ff),
        .o_rdata_b(coef_b)
    );

    assign start_p = i_wr && i_addr == REG_CTRL && i_wdata[0];
    assign upd_p = i_wr && i_addr == REG_CTRL && i_wdata[2];
    assign dclr_p = i_wr && i_addr == REG_CTRL && i_wdata[3];

    always_comb begin
        status = '0;
        status.eng = eng_ff;
        status.wait_coef = (state_ff == ST_COEFWAIT);
        status.run = run_ff;
        status.fail = fail_ff;
        status.drift = drift_ff;
        status.done = done_ff;
        status.clk_final = clkf_ff;
        nxt_ctrl = ctrl_ff;
        nxt_cfg = cfg_ff;
        nxt_off_lim = off_lim_ff;
        nxt_gain_lim = gain_lim_ff;
        nxt_noise = noise_ff;
        nxt_csel = {1'b0, csel_ff[0]};
        nxt_rdata = rdata_ff;
        if (i_wr) begin
            case (i_addr)
                REG_CTRL: nxt_ctrl.run_en = i_wdata[1];
                REG_CFG: nxt_cfg = i_wdata;
                REG_OFF_LIM: nxt_off_lim = i_wdata;
                REG_GAIN_LIM: nxt_gain_lim = i_wdata;
                REG_NOISE: nxt_noise = i_wdata;
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        if (i_rd) begin
            nxt_csel = {is_coef(i_addr), i_addr[0]};
            if (i_addr == REG_CTRL) nxt_rdata = ctrl_ff;
            else if (i_addr == REG_CFG) nxt_rdata = cfg_ff;
            else if (i_addr == REG_OFF_LIM) nxt_rdata = off_lim_ff;
            else if (i_addr == REG_GAIN_LIM) nxt_rdata = gain_lim_ff;
            else if (i_addr == REG_NOISE) nxt_rdata = noise_ff;
            else if (i_addr == REG_STATUS) nxt_rdata = status;
            else if (i_addr[3:2] == REG_FILT0[3:2] || i_addr[3:1] == 3'b100)
                nxt_rdata = avg_ff[2'(i_addr - REG_FILT0)];
            else nxt_rdata = 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_ff <= '0;
            cfg_ff <= CFG_RST;
            off_lim_ff <= OFF_LIM_RST;
            gain_lim_ff <= GAIN_LIM_RST;
            noise_ff <= NOISE_RST;
            csel_ff <= 2'h0;
            rdata_ff <= 16'h0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cfg_ff <= nxt_cfg;
            off_lim_ff <= nxt_off_lim;
            gain_lim_ff <= nxt_gain_lim;
            noise_ff <= nxt_noise;
            csel_ff <= nxt_csel;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = csel_ff[1] ? (csel_ff[0] ? coef_a[31:16] : coef_a[15:0]) : rdata_ff;
    assign o_clk_final = clkf_ff;
    assign o_cmd_valid = cval_ff;
    assign o_cmd = cmd_ff;
    assign accepted = cval_ff && i_cmd_ready;
    assign tot = 9'h002 << (vfy_ff || run_ff ? 3'h0 : cfg_ff.nlog);
    assign idx = {eng_ff, i_res.tag[0]};
    assign ideal = i_res.tag[0] ? IDEAL_75 : IDEAL_25;
    assign off_ok = mag(17'(signed'(coef_b[13:0]))) <= {3'h0, off_lim_ff[13:0]};
    assign gain_ok = mag(17'(signed'({2'b00, coef_b[30:16]} - {2'b00, GAIN_ONE})))
                     <= {2'h0, gain_lim_ff[14:0]};
    assign diff = signed'({1'b0, i_res.data}) - signed'({1'b0, avg_ff[idx]});
    assign step = diff >>> cfg_ff.fgain;
    assign filt = avg_ff[idx] + step[15:0];

    always_comb begin
        nxt_state = state_ff;
        nxt_eng = eng_ff;
        nxt_clkf = clkf_ff;
        nxt_run = run_ff;
        nxt_vfy = vfy_ff;
        nxt_fail = fail_ff;
        nxt_bad = bad_ff;
        nxt_cval = cval_ff;
        nxt_done = done_ff;
        nxt_drift = dclr_p ? 2'b00 : drift_ff;
        nxt_cnt = cnt_ff;
        nxt_sum25 = sum25_ff;
        nxt_sum75 = sum75_ff;
        nxt_avg = avg_ff;
        nxt_base = base_ff;
        nxt_tmr = tmr_ff;
        nxt_ctmr = ctmr_ff;
        nxt_cmd = cmd_ff;
        // An update that lands during a run-mode read is held until the sequencer can act.
        nxt_upd_req = upd_req_ff || (upd_p && (run_ff || state_ff == ST_COEFWAIT));
        nxt_pwr = (pwr_ff == REF_CYCLES) ? pwr_ff : pwr_ff + 32'd1;
        if (run_ff && ctmr_ff != CAL_CYCLES - 1) nxt_ctmr = ctmr_ff + 32'd1;
        case (state_ff)
            ST_ENABLE: begin
                nxt_clkf = 1'b1;
                if (!cval_ff && clkf_ff) begin
                    nxt_cval = 1'b1;
                    nxt_cmd = mk_cmd(cnt_ff[0], 1'b1, 1'b1, ENG_CTRL, ENABLE_WORD, 1'b0, 1'b0);
                end else if (accepted) begin
                    nxt_cval = 1'b0;
                    nxt_cnt = 9'h001;
                    nxt_tmr = 32'h0;
                    if (cnt_ff[0]) nxt_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                nxt_tmr = tmr_ff + 32'd1;
                if (tmr_ff == SETTLE_CYCLES - 1) nxt_state = ST_REFWAIT;
            end
            ST_REFWAIT: begin
                if (pwr_ff == REF_CYCLES) begin
                    nxt_state = ST_SAMPLE;
                    nxt_eng = 1'b0;
                    nxt_cnt = 9'h000;
                end
            end
            ST_SAMPLE: begin
                // One conversion in flight at a time, so engines never share a reference.
                if (!cval_ff) begin
                    nxt_cval = 1'b1;
                    nxt_cmd = mk_cmd(eng_ff, 1'b0, 1'b0, ENG_CONV, 16'h0000,
                                     cnt_ff[0], vfy_ff);
                end else if (i_cmd_ready) begin
                    nxt_cval = 1'b0;
                    nxt_cnt = cnt_ff + 9'h001;
                    nxt_state = ST_WAITRES;
                end
            end
            ST_WAITRES: begin
                if (i_res_valid && i_res.engine == eng_ff) begin
                    nxt_state = ST_SAMPLE;
                    if (vfy_ff) begin
                        nxt_bad = bad_ff
                            || mag(signed'({1'b0, i_res.data}) - signed'({1'b0, ideal}))
                               > {1'b0, noise_ff};
                    end else if (run_ff) begin
                        nxt_avg[idx] = filt;
                        if (mag(signed'({1'b0, filt}) - signed'({1'b0, base_ff[idx]}))
                            >= {14'h0, cfg_ff.drift_thr})
                            nxt_drift[eng_ff] = 1'b1;
                    end else if (i_res.tag[0] == CHAN_25) begin
                        nxt_sum25 = sum25_ff + {8'h00, i_res.data};
                    end else begin
                        nxt_sum75 = sum75_ff + {8'h00, i_res.data};
                    end
                    if (cnt_ff == tot) begin
                        nxt_cnt = 9'h000;
                        if (run_ff) begin
                            nxt_state = ST_RUN;
                        end else if (!vfy_ff) begin
                            nxt_avg[{eng_ff, CHAN_25}] = 16'(nxt_sum25 >> cfg_ff.nlog);
                            nxt_avg[{eng_ff, CHAN_75}] = 16'(nxt_sum75 >> cfg_ff.nlog);
                            nxt_state = ST_COEFWAIT;
                        end else if (nxt_bad) begin
                            nxt_state = ST_FAIL;
                            nxt_fail = 1'b1;
                        end else begin
                            nxt_done[eng_ff] = 1'b1;
                            nxt_base[{eng_ff, CHAN_25}] = avg_ff[{eng_ff, CHAN_25}];
                            nxt_base[{eng_ff, CHAN_75}] = avg_ff[{eng_ff, CHAN_75}];
                            nxt_vfy = 1'b0;
                            nxt_sum25 = 24'h0;
                            nxt_sum75 = 24'h0;
                            if (!eng_ff) nxt_eng = 1'b1;
                            else if (ctrl_ff.run_en) nxt_state = ST_RUN;
                            else nxt_state = ST_IDLE;
                            nxt_run = eng_ff && ctrl_ff.run_en;
                            nxt_tmr = 32'h0;
                            nxt_ctmr = 32'h0;
                            nxt_eng = !eng_ff;
                        end
                    end
                end
            end
            ST_COEFWAIT: begin
                if (upd_req_ff) nxt_state = ST_CHECK;
            end
            ST_CHECK: begin
                nxt_upd_req = upd_p && run_ff;
                nxt_state = (off_ok && gain_ok) ? ST_WR_OFF : ST_FAIL;
                nxt_fail = !(off_ok && gain_ok);
            end
            ST_WR_OFF, ST_WR_GAIN: begin
                if (!cval_ff) begin
                    nxt_cval = 1'b1;
                    nxt_cmd = (state_ff == ST_WR_OFF)
                        ? mk_cmd(eng_ff, 1'b1, 1'b1, ENG_OFFS, {2'b00, coef_b[13:0]}, 1'b0, 1'b0)
                        : mk_cmd(eng_ff, 1'b1, 1'b1, ENG_GAIN, {1'b0, coef_b[30:16]},
                                 1'b0, 1'b0);
                end else if (i_cmd_ready) begin
                    nxt_cval = 1'b0;
                    if (state_ff == ST_WR_OFF) begin
                        nxt_state = ST_WR_GAIN;
                    end else if (run_ff) begin
                        nxt_state = ST_RUN;
                        nxt_base[{eng_ff, CHAN_25}] = avg_ff[{eng_ff, CHAN_25}];
                        nxt_base[{eng_ff, CHAN_75}] = avg_ff[{eng_ff, CHAN_75}];
                    end else begin
                        nxt_state = ST_SAMPLE;
                        nxt_vfy = 1'b1;
                        nxt_bad = 1'b0;
                    end
                end
            end
            ST_RUN: begin
                nxt_tmr = tmr_ff + 32'd1;
                if (tmr_ff == RT_CYCLES - 1) begin
                    nxt_tmr = 32'h0;
                    nxt_state = ST_SAMPLE;
                end else if (ctmr_ff == CAL_CYCLES - 1) begin
                    nxt_ctmr = 32'h0;
                    nxt_eng = !eng_ff;
                end else if (upd_req_ff) begin
                    nxt_state = ST_CHECK;
                end
            end
            ST_IDLE, ST_FAIL: nxt_state = state_ff;
            default: nxt_state = ST_IDLE;
        endcase
        if (start_p && (state_ff == ST_IDLE || state_ff == ST_FAIL || state_ff == ST_RUN
                        || state_ff == ST_COEFWAIT)) begin
            nxt_state = ST_SAMPLE;
            nxt_eng = 1'b0;
            nxt_cnt = 9'h000;
            nxt_run = 1'b0;
            nxt_vfy = 1'b0;
            nxt_fail = 1'b0;
            nxt_upd_req = 1'b0;
            nxt_sum25 = 24'h0;
            nxt_sum75 = 24'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_ENABLE;
            {eng_ff, clkf_ff, run_ff, vfy_ff, fail_ff, bad_ff, cval_ff, upd_req_ff} <= 8'h00;
            done_ff <= 2'b00;
            drift_ff <= 2'b00;
            cnt_ff <= 9'h000;
            sum25_ff <= 24'h0;
            sum75_ff <= 24'h0;
            avg_ff <= '{default: 16'h0000};
            base_ff <= '{default: 16'h0000};
            tmr_ff <= 32'h0;
            ctmr_ff <= 32'h0;
            pwr_ff <= 32'h0;
            cmd_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            {eng_ff, clkf_ff, run_ff, vfy_ff} <= {nxt_eng, nxt_clkf, nxt_run, nxt_vfy};
            {fail_ff, bad_ff, cval_ff, upd_req_ff} <= {nxt_fail, nxt_bad, nxt_cval, nxt_upd_req};
            done_ff <= nxt_done;
            drift_ff <= nxt_drift;
            cnt_ff <= nxt_cnt;
            sum25_ff <= nxt_sum25;
            sum75_ff <= nxt_sum75;
            avg_ff <= nxt_avg;
            base_ff <= nxt_base;
            tmr_ff <= nxt_tmr;
            ctmr_ff <= nxt_ctmr;
            pwr_ff <= nxt_pwr;
            cmd_ff <= nxt_cmd;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence off_wr_s;
        accepted && cmd_ff.reg_wr && cmd_ff.reg_addr == ENG_OFFS;
    endsequence
    sequence gain_wr_s;
        cval_ff && cmd_ff.reg_wr && cmd_ff.reg_addr == ENG_GAIN && cmd_ff.top_q;
    endsequence

    clk_before_enable_a: assert property (
        (o_cmd_valid && o_cmd.reg_wr && o_cmd.reg_addr == ENG_CTRL) |-> $past(o_clk_final))
        else $error("engine enabled before final clock");
    ref_settled_a: assert property (
        (o_cmd_valid && !o_cmd.reg_wr) |-> pwr_ff == REF_CYCLES)
        else $error("reference read before settling");
    single_conv_a: assert property (
        (accepted && !o_cmd.reg_wr) |=> !o_cmd_valid [*2])
        else $error("second conversion while one in flight");
    coef_top_a: assert property (
        (o_cmd_valid && o_cmd.reg_wr && (o_cmd.reg_addr == ENG_OFFS
         || o_cmd.reg_addr == ENG_GAIN)) |-> o_cmd.top_q)
        else $error("coefficient write below top queue");
    coef_pair_a: assert property (
        off_wr_s |-> ##[1:2] gain_wr_s)
        else $error("gain write does not follow offset write");
endmodule : acs_cal_seq

// ==== tb/acs_eng_model.sv ====
`timescale 1ns/10ps
module acs_eng_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Commands
    input wire logic i_cmd_valid,
    input wire acs_pkg::acs_cmd_t i_cmd,
    output logic o_cmd_ready,
    // Results and knobs
    input wire logic i_slow,
    input wire logic [15:0] i_bias,
    output logic o_res_valid,
    output acs_pkg::acs_res_t o_res,
    output logic o_bad
);
    import acs_pkg::*;
    logic [1:0] en_ff;
    logic [1:0] coef_ff;
    logic busy_ff;
    logic stall_ff;
    logic [3:0] cnt_ff;
    acs_cmd_t cur_ff;
    assign o_cmd_ready = !busy_ff && !(i_slow && stall_ff);
    always_ff @(posedge i_clk) begin
        stall_ff <= !stall_ff;
        o_res_valid <= 1'b0;
        o_res <= ~o_res;
        if (i_sys_rst) begin
            {en_ff, coef_ff, busy_ff, stall_ff, o_bad} <= '0;
            o_res <= '0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
            if (cnt_ff == 4'h0) begin
                busy_ff <= 1'b0;
                o_res_valid <= 1'b1;
                o_res <= '{cur_ff.engine, cur_ff.tag,
                           (cur_ff.chan ? IDEAL_75 : IDEAL_25) + i_bias};
            end
        end else if (i_cmd_valid && o_cmd_ready) begin
            if (i_cmd.reg_wr && i_cmd.reg_addr == ENG_CTRL) begin
                en_ff[i_cmd.engine] <= 1'b1;
            end
            if (i_cmd.reg_wr && i_cmd.reg_addr == ENG_GAIN) begin
                coef_ff[i_cmd.engine] <= 1'b1;
            end
            if (!i_cmd.reg_wr) begin
                o_bad <= o_bad | !en_ff[i_cmd.engine]
                         | (i_cmd.cal_apply & !coef_ff[i_cmd.engine]);
                busy_ff <= 1'b1;
                cnt_ff <= i_slow ? 4'hc : 4'h2;
                cur_ff <= i_cmd;
            end
        end
    end
endmodule : acs_eng_model

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    import acs_pkg::*;
    logic i_clk, i_sys_rst, i_wr, i_rd, o_clk_final, o_cmd_valid, i_cmd_ready, i_res_valid;
    logic slow, bad, last_off;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, bias, v, seed;
    logic [13:0] exp_off [2];
    acs_cmd_t o_cmd;
    acs_res_t i_res;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int en_cyc = 0;
    acs_cal_seq #(.SETTLE_CYCLES(20), .REF_CYCLES(50), .RT_CYCLES(100), .CAL_CYCLES(300)) uut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_clk_final(o_clk_final), .o_cmd_valid(o_cmd_valid),
        .o_cmd(o_cmd), .i_cmd_ready(i_cmd_ready), .i_res_valid(i_res_valid), .i_res(i_res));
    acs_eng_model eng (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(o_cmd_valid),
        .i_cmd(o_cmd), .o_cmd_ready(i_cmd_ready), .i_slow(slow), .i_bias(bias),
        .o_res_valid(i_res_valid), .o_res(i_res), .o_bad(bad));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [15:0] exp_samp(input logic ch);
        return {9'h0, ch ? SAMP_75 : SAMP_25};
    endfunction : exp_samp
    function automatic logic [15:0] filt_step(input logic [15:0] f, input logic [15:0] x,
                                              input int k);
        return f + 16'(($signed({1'b0, x}) - $signed({1'b0, f})) >>> k);
    endfunction : filt_step
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (e !== g) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd
    task automatic wait_mask(input logic [15:0] m);
        int n = 0;
        v = '0;
        while ((v & m) === 16'h0 && n < 3000) begin
            rd(REG_STATUS);
            n++;
        end
        chk("status", 16'h1, {15'h0, (v & m) != 16'h0});
    endtask : wait_mask
    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge i_clk) begin
        cyc <= i_sys_rst ? 0 : cyc + 1;
        if (!i_sys_rst && o_cmd_valid && i_cmd_ready) begin
            if (!o_cmd.reg_wr) begin
                chk("clk_final", 16'h1, {15'h0, o_clk_final});
                chk("ref_wait", 16'h1, {15'h0, cyc >= 50});
                chk("settle", 16'h1, {15'h0, cyc - en_cyc >= 20});
                chk("samp", exp_samp(o_cmd.chan), {9'h0, o_cmd.samp});
                chk("tag", {15'h0, o_cmd.chan}, {15'h0, o_cmd.tag[0]});
                chk("low_queue", 16'h0, {15'h0, o_cmd.top_q});
            end else if (o_cmd.reg_addr == ENG_CTRL) begin
                en_cyc <= cyc;
            end else if (o_cmd.reg_addr == ENG_OFFS) begin
                chk("top_queue", 16'h1, {15'h0, o_cmd.top_q});
                chk("offset", {2'h0, exp_off[o_cmd.engine]}, {2'h0, o_cmd.data[13:0]});
                last_off <= 1'b1;
            end else if (o_cmd.reg_addr == ENG_GAIN) begin
                chk("top_queue", 16'h1, {15'h0, o_cmd.top_q});
                chk("pairing", 16'h1, {15'h0, last_off});
                chk("gain", {1'h0, GAIN_ONE}, {1'h0, o_cmd.data[14:0]});
                last_off <= 1'b0;
            end
        end
    end
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        finish_test();
    end
    initial begin
        {i_sys_rst, i_wr, i_rd, slow, last_off} = 5'h10;
        {i_addr, i_wdata, bias} = '0;
        seed = 16'h5252;
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(REG_CFG);
        chk("cfg", CFG_RST, v);
        rd(REG_OFF_LIM);
        chk("off_lim", OFF_LIM_RST, v);
        rd(REG_GAIN_LIM);
        chk("gain_lim", GAIN_LIM_RST, v);
        rd(REG_NOISE);
        chk("noise", NOISE_RST, v);
        rd(4'ha);
        chk("unmapped", 16'h0, v);
        wr(REG_CFG, 16'h0230);
        wr(REG_CTRL, 16'h0002);
        for (int e = 0; e < 2; e++) begin
            wait_mask(16'h0080);
            rd(REG_FILT0 + 4'(2 * e));
            chk("mean25", IDEAL_25, v);
            rd(REG_FILT0 + 4'(2 * e + 1));
            chk("mean75", IDEAL_75, v);
            seed = lfsr(seed);
            exp_off[e] = {{6{seed[7]}}, seed[7:0]};
            wr(REG_COEF0 + 4'(2 * e), {2'h0, exp_off[e]});
            wr(REG_COEF0 + 4'(2 * e + 1), {1'h0, GAIN_ONE});
            wr(REG_CTRL, 16'h0006);
        end
        wait_mask(16'h0040);
        rd(REG_STATUS);
        chk("done", 16'h0006, v & 16'h0026);
        slow <= 1'b1;
        bias <= 16'h0040;
        wait_mask(16'h0018);
        rd(REG_FILT0);
        chk("filter", filt_step(IDEAL_25, IDEAL_25 + 16'h0040, 3), v);
        wait_mask(16'h0100);
        wr(REG_COEF0, 16'h0200);
        wr(REG_COEF0 + 4'h2, 16'h0200);
        wr(REG_CTRL, 16'h0006);
        wait_mask(16'h0020);
        wr(REG_CTRL, 16'h0009);
        rd(REG_STATUS);
        chk("drift_clr", 16'h0, v & 16'h0038);
        wait_mask(16'h0080);
        rd(REG_FILT0);
        chk("restart_mean", IDEAL_25 + 16'h0040, v);
        chk("engine_enable", 16'h0, {15'h0, bad});
        finish_test();
    end
endmodule : tb
